// ---- logic/pbc_regs.vh ----
// Register offsets, field positions, reset values and timing for the bypass channel
// Included by pbc_sync_filt and pbc_channel; no logic here
`ifndef PBC_REGS_VH
`define PBC_REGS_VH
`define PBC_CTRL_OFS 8'h29
`define PBC_ISRC_OFS 8'h2A
`define PBC_STAT_OFS 8'h2B
`define PBC_MASK_OFS 8'h2C
`define PBC_CFG_OFS 8'h2D
`define PBC_BIT_EN 7
`define PBC_BIT_IEN 6
`define PBC_BIT_FB 1
`define PBC_BIT_SD 0
`define PBC_ST_SDEDGE 0
`define PBC_ST_LOSS 1
`define PBC_CTRL_RST 8'h02
`define PBC_STAT_RST 2'h0
`define PBC_MASK_RST 2'h1
`define PBC_IRQ_SRC_VAL 8'h29
`define PBC_FILT_LEN 3
`define PBC_LOSS_MAX_NS 400
`define PBC_CLK_NS 10
`define PBC_LOSS_MAX_CYC (`PBC_LOSS_MAX_NS / `PBC_CLK_NS)
`endif

// ---- logic/pbc_sync_filt.v ----
// Two-stage synchroniser followed by a majority-free stability filter
// Assumes one clock; input may be asynchronous in practice
`timescale 1ns/1ps
`include "pbc_regs.vh"
module pbc_sync_filt #(
	parameter FILT_LEN = `PBC_FILT_LEN
) (
	input wire clk_sys,
	input wire rst_n_sync,
	input wire din,
	output reg dout_r
);
	reg s1_r;
	reg s2_r;
	reg [7:0] cnt_r;
	always @(posedge clk_sys or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			cnt_r <= 8'h00;
			dout_r <= 1'b1;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			if (s2_r == dout_r) begin
				cnt_r <= 8'h00;
			end else if (cnt_r >= FILT_LEN[7:0] - 8'h01) begin
				cnt_r <= 8'h00;
				dout_r <= s2_r;
			end else begin
				cnt_r <= cnt_r + 8'h01;
			end
		end
	end
endmodule

// ---- logic/pbc_edge_det.v ----
// Both-edge detector giving one pulse per change of a filtered level
// Assumes input already synchronous
`timescale 1ns/1ps
module pbc_edge_det (
	input wire clk_sys,
	input wire rst_n_sync,
	input wire level,
	output wire edge_pulse
);
	reg last_r;
	always @(posedge clk_sys or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			last_r <= 1'b1;
		end else begin
			last_r <= level;
		end
	end
	assign edge_pulse = level ^ last_r;
endmodule

// ---- logic/pbc_channel.v ----
// Port bypass channel nine: control register, pin muxing, signal-detect interrupt
// Assumes synchronous register port with read data one cycle after read strobe
`timescale 1ns/1ps
`include "pbc_regs.vh"

// Notes on behaviour
// - Enable bit set makes pin 3 the bypass output and pin 2 the detect input.
// - Enable overrides other pin configuration; bypass-select bits still pass through.
// - With enable clear, irq enable and bypass bit do not touch the pins.
// - Enable and irq enable set: any filtered detect pin transition raises an interrupt condition.
// - Detect interrupt drives interrupt low and loads source register with 29h.
// - Irq enable clear: detect transitions make no interrupt condition, except a fall with enable and bypass bit set, which sets loss status.
// - Bypass bit drives pin 3 as a push-pull output when enabled.
// - Bypass bit set keeps external bypass input inactive: normal mode.
// - Bypass bit clear activates external bypass input: bypass mode.
// - Filtered detect low clears bypass bit; output drops within 400 ns.
// - Detect bit reads the filtered pin, read-only while enabled.
module pbc_channel (
	input wire clk_sys,
	input wire rst_n,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata_r,
	input wire gp_p53_out,
	input wire gp_p53_oe_n,
	input wire [1:0] bypass_sel,
	input wire port5_bit3_pin_in,
	output reg port5_bit3_pin_out_r,
	output reg port5_bit3_pin_oe_n_r,
	input wire port5_bit2_pin_in,
	input wire gp_p52_out,
	input wire gp_p52_oe_n,
	output reg port5_bit2_pin_out_r,
	output reg port5_bit2_pin_oe_n_r,
	output reg [1:0] bypass_sel_r,
	output reg [7:0] interrupt_source_reg_r,
	output reg irq_n_r,
	output reg irq_r
);
	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	function addr_hit;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			addr_hit = (addr == ofs);
		end
	endfunction

	function irq_any;
		input [1:0] stat;
		input [1:0] mask;
		begin
			irq_any = |(stat & mask);
		end
	endfunction

	function [7:0] pack_ctrl;
		input en;
		input ien;
		input fb;
		input sd;
		begin
			pack_ctrl = {en, ien, 4'h0, fb, sd};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Reset release
	reg rst_a_r;
	reg rst_b_r;
	wire rst_n_sync;
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_a_r <= 1'b0;
			rst_b_r <= 1'b0;
		end else begin
			rst_a_r <= 1'b1;
			rst_b_r <= rst_a_r;
		end
	end
	assign rst_n_sync = rst_b_r;

	////////////////////////////////////////////////////////////////////////////////
	// Input conditioning
	wire sd_filt;
	wire sd_edge;
	wire p53_filt;
	pbc_sync_filt #(.FILT_LEN(`PBC_FILT_LEN)) u_sd_filt (
		.clk_sys(clk_sys),
		.rst_n_sync(rst_n_sync),
		.din(port5_bit2_pin_in),
		.dout_r(sd_filt)
	);
	pbc_sync_filt #(.FILT_LEN(`PBC_FILT_LEN)) u_fb_filt (
		.clk_sys(clk_sys),
		.rst_n_sync(rst_n_sync),
		.din(port5_bit3_pin_in),
		.dout_r(p53_filt)
	);
	pbc_edge_det u_sd_edge (
		.clk_sys(clk_sys),
		.rst_n_sync(rst_n_sync),
		.level(sd_filt),
		.edge_pulse(sd_edge)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	localparam [7:0] CTRL_RST = `PBC_CTRL_RST;
	reg channel_enable_r;
	reg signal_detect_irq_enable_r;
	reg force_bypass_r;
	reg force_bypass_nxt;
	reg [1:0] stat_r;
	reg [1:0] stat_nxt;
	reg [1:0] mask_r;
	reg [7:0] rdata_nxt;
	reg irq_any_nxt;
	wire wr_ctrl;
	wire wr_stat;
	wire wr_mask;
	wire sd_irq_gate;
	wire fb_read;
	wire sd_read;
	wire [1:0] ev;

	////////////////////////////////////////////////////////////////////////////////
	// Write decode
	assign wr_ctrl = reg_wr && addr_hit(reg_addr, `PBC_CTRL_OFS);
	assign wr_stat = reg_wr && addr_hit(reg_addr, `PBC_STAT_OFS);
	assign wr_mask = reg_wr && addr_hit(reg_addr, `PBC_MASK_OFS);

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt events
	// Detect edge event only when enabled and armed
	assign sd_irq_gate = channel_enable_r && signal_detect_irq_enable_r;
	assign ev[`PBC_ST_SDEDGE] = sd_irq_gate && sd_edge;
	// Loss event while the bypass bit still holds normal mode
	assign ev[`PBC_ST_LOSS] = channel_enable_r && force_bypass_r && !sd_filt;

	////////////////////////////////////////////////////////////////////////////////
	// Force-bypass next value
	always @* begin
		force_bypass_nxt = force_bypass_r;
		if (wr_ctrl) begin
			force_bypass_nxt = reg_wdata[`PBC_BIT_FB];
		end
		// Loss of signal overrides any write
		if (!sd_filt) begin
			force_bypass_nxt = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status next value
	always @* begin
		// Set wins over write-one-to-clear
		stat_nxt = stat_r;
		if (wr_stat) begin
			stat_nxt = stat_r & ~reg_wdata[1:0];
		end
		stat_nxt = stat_nxt | ev;
		irq_any_nxt = irq_any(stat_nxt, mask_r);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data select
	// Disabled channel reads the filtered pin 3 level in bit 1 and the pin 2 output register in bit 0
	assign fb_read = channel_enable_r ? force_bypass_r : p53_filt;
	assign sd_read = channel_enable_r ? sd_filt : port5_bit2_pin_out_r;
	always @* begin
		case (reg_addr)
			`PBC_CTRL_OFS: begin
				rdata_nxt = pack_ctrl(channel_enable_r, signal_detect_irq_enable_r,
					fb_read, sd_read);
			end
			`PBC_ISRC_OFS: begin
				rdata_nxt = interrupt_source_reg_r;
			end
			`PBC_STAT_OFS: begin
				rdata_nxt = {6'h00, stat_r};
			end
			`PBC_MASK_OFS: begin
				rdata_nxt = {6'h00, mask_r};
			end
			default: begin
				rdata_nxt = 8'h00;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control register
	always @(posedge clk_sys or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			channel_enable_r <= CTRL_RST[`PBC_BIT_EN];
			signal_detect_irq_enable_r <= CTRL_RST[`PBC_BIT_IEN];
		end else if (wr_ctrl) begin
			channel_enable_r <= reg_wdata[`PBC_BIT_EN];
			signal_detect_irq_enable_r <= reg_wdata[`PBC_BIT_IEN];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Force-bypass register
	always @(posedge clk_sys or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			force_bypass_r <= CTRL_RST[`PBC_BIT_FB];
		end else begin
			force_bypass_r <= force_bypass_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status and mask
	always @(posedge clk_sys or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			stat_r <= `PBC_STAT_RST;
			mask_r <= `PBC_MASK_RST;
		end else begin
			stat_r <= stat_nxt;
			if (wr_mask) begin
				mask_r <= reg_wdata[1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data, valid one cycle after the strobe
	always @(posedge clk_sys or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			reg_rdata_r <= 8'h00;
		end else begin
			reg_rdata_r <= reg_rd ? rdata_nxt : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt source
	always @(posedge clk_sys or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			interrupt_source_reg_r <= 8'h00;
		end else if (ev[`PBC_ST_SDEDGE]) begin
			interrupt_source_reg_r <= `PBC_IRQ_SRC_VAL;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt outputs, in step with the status register
	always @(posedge clk_sys or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			irq_n_r <= 1'b1;
			irq_r <= 1'b0;
		end else begin
			irq_n_r <= ~irq_any_nxt;
			irq_r <= irq_any_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bypass select pass-through
	always @(posedge clk_sys or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			bypass_sel_r <= 2'h0;
		end else begin
			bypass_sel_r <= bypass_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin 3: force-bypass output
	always @(posedge clk_sys or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			port5_bit3_pin_out_r <= 1'b1;
			port5_bit3_pin_oe_n_r <= 1'b1;
		end else if (channel_enable_r) begin
			// High keeps bypass inactive, low forces bypass
			port5_bit3_pin_out_r <= force_bypass_nxt;
			port5_bit3_pin_oe_n_r <= 1'b0;
		end else begin
			port5_bit3_pin_out_r <= gp_p53_out;
			port5_bit3_pin_oe_n_r <= gp_p53_oe_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin 2: signal-detect input
	always @(posedge clk_sys or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			port5_bit2_pin_out_r <= 1'b1;
			port5_bit2_pin_oe_n_r <= 1'b1;
		end else if (channel_enable_r) begin
			port5_bit2_pin_out_r <= 1'b1;
			port5_bit2_pin_oe_n_r <= 1'b1;
		end else begin
			port5_bit2_pin_out_r <= gp_p52_out;
			port5_bit2_pin_oe_n_r <= gp_p52_oe_n;
		end
	end
endmodule

// ---- bench/pbc_channel_props.sv ----
// Port assertions for the bypass channel
// Assumes binding to pbc_channel; register writes tracked locally
`timescale 1ns/1ps
module pbc_channel_props (
	input clk_sys,
	input rst_n,
	input [7:0] reg_addr,
	input [7:0] reg_wdata,
	input reg_wr,
	input reg_rd,
	input [7:0] reg_rdata_r,
	input [1:0] bypass_sel,
	input [1:0] bypass_sel_r,
	input port5_bit2_pin_in,
	input port5_bit3_pin_out_r,
	input port5_bit3_pin_oe_n_r,
	input port5_bit2_pin_oe_n_r,
	input [7:0] interrupt_source_reg_r,
	input irq_n_r,
	input irq_r
);
	reg en_r, ien_r, msk_r;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			{en_r, ien_r, msk_r} <= 3'h1;
		else if (reg_wr && reg_addr == 8'h29)
			{en_r, ien_r} <= reg_wdata[7:6];
		else if (reg_wr && reg_addr == 8'h2C)
			msk_r <= reg_wdata[0];
	end
	sequence sd_moved;
		en_r && ien_r && msk_r && $changed(port5_bit2_pin_in) ##1 $stable(port5_bit2_pin_in) [*8];
	endsequence
	sequence sd_lost;
		en_r && $fell(port5_bit2_pin_in) ##1 (en_r && !port5_bit2_pin_in) [*8];
	endsequence
	pins_en_a: assert property (en_r [*3] |-> !port5_bit3_pin_oe_n_r && port5_bit2_pin_oe_n_r)
		else $error("pins not taken by enabled channel");
	sel_pass_a: assert property ($past(rst_n, 3) |-> bypass_sel_r == $past(bypass_sel))
		else $error("bypass select not passed through");
	edge_irq_a: assert property (sd_moved |-> !irq_n_r)
		else $error("detect edge raised no interrupt");
	src_code_a: assert property ($fell(irq_n_r) |-> interrupt_source_reg_r == 8'h29)
		else $error("interrupt source code wrong");
	no_ien_a: assert property (!ien_r [*8] |-> !$fell(irq_n_r))
		else $error("interrupt with detect irq disabled");
	loss_out_a: assert property (sd_lost |-> !port5_bit3_pin_out_r)
		else $error("bypass output kept after signal loss");
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_r == 8'h00)
		else $error("read data outside read slot");
	irq_twin_a: assert property (irq_r == !irq_n_r)
		else $error("interrupt outputs disagree");
endmodule
bind pbc_channel pbc_channel_props pbc_channel_props_inst (.*);

// ---- bench/pbc_bypass_unit.sv ----
// Far-side bypass circuit with signal detect
// Assumes pull-up on the bypass pin when undriven
`timescale 1ns/1ps
module pbc_bypass_unit (
	input fb_out,
	input fb_oe_n,
	input sig_present,
	output sd_pin,
	output bypassed
);
	assign sd_pin = sig_present;
	assign bypassed = !(fb_oe_n | fb_out);
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench for the bypass channel
// Assumes pbc_channel and pbc_bypass_unit compiled first
`timescale 1ns/1ps
module testbench;
	reg clk_sys = 1'h0;
	reg rst_n = 1'h0;
	reg [7:0] reg_addr = 8'h00;
	reg [7:0] reg_wdata = 8'h00;
	reg reg_wr = 1'h0;
	reg reg_rd = 1'h0;
	reg [1:0] bypass_sel = 2'h2;
	reg sig = 1'h1;
	reg gp3 = 1'h1;
	wire [7:0] rdata, isrc;
	wire [1:0] sel_q;
	wire out3, oe3, out2, oe2, sd, byp, irq_n;
	integer errors = 0;
	integer tests_run = 0;
	integer cyc = 0;
	pbc_channel pbc_channel_inst (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(rdata),
		.gp_p53_out(gp3), .gp_p53_oe_n(1'h0), .bypass_sel(bypass_sel),
		.port5_bit3_pin_in(oe3 | out3), .port5_bit3_pin_out_r(out3),
		.port5_bit3_pin_oe_n_r(oe3), .port5_bit2_pin_in(sd), .gp_p52_out(1'h0),
		.gp_p52_oe_n(1'h1), .port5_bit2_pin_out_r(out2), .port5_bit2_pin_oe_n_r(oe2),
		.bypass_sel_r(sel_q), .interrupt_source_reg_r(isrc), .irq_n_r(irq_n), .irq_r());
	pbc_bypass_unit pbc_bypass_unit_inst (.fb_out(out3), .fb_oe_n(oe3), .sig_present(sig),
		.sd_pin(sd), .bypassed(byp));
	initial forever #5 clk_sys = ~clk_sys;
	task chk(input [7:0] g, input [7:0] e);
		begin
			tests_run = tests_run + 1;
			if (g !== e) begin
				errors = errors + 1;
				$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task wt(input integer n);
		repeat (n) @(posedge clk_sys);
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk_sys);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'h1;
			@(posedge clk_sys);
			reg_wr <= 1'h0;
		end
	endtask
	task rd(input [7:0] a, input [7:0] e, input [7:0] m);
		begin
			@(posedge clk_sys);
			reg_addr <= a;
			reg_rd <= 1'h1;
			@(posedge clk_sys);
			reg_rd <= 1'h0;
			#1 chk(rdata & m, e);
		end
	endtask
	task test_done;
		begin
			$display("errors %0d tests_run %0d", errors, tests_run);
			if (errors == 0 && tests_run > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			errors = errors + 1;
			test_done;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		wt(12);
		rst_n <= 1'h1;
		wt(4);
		rd(8'h29, 8'h02, 8'hFE);
		rd(8'h2C, 8'h01, 8'hFF);
		rd(8'h2D, 8'h00, 8'hFF);
		wr(8'h29, 8'h42);
		gp3 <= 1'h0;
		wt(3);
		chk({oe3, out3, oe2, out2}, 8'h02);
		sig <= 1'h0;
		wt(10);
		chk(irq_n, 8'h01);
		sig <= 1'h1;
		wt(10);
		wr(8'h29, 8'h42);
		rd(8'h29, 8'h40, 8'hFE);
		wr(8'h29, 8'hC2);
		wt(3);
		chk({oe3, out3, oe2, out2, byp}, 8'h0E);
		chk(sel_q, 8'h02);
		bypass_sel <= 2'h1;
		rd(8'h29, 8'hC3, 8'hFF);
		wr(8'h29, 8'hC0);
		wt(3);
		chk({out3, byp}, 8'h01);
		chk(sel_q, 8'h01);
		wr(8'h29, 8'hC2);
		sig <= 1'h0;
		wt(10);
		chk({irq_n, out3}, 8'h00);
		chk(isrc, 8'h29);
		rd(8'h29, 8'hC0, 8'hFF);
		rd(8'h2B, 8'h01, 8'h01);
		wr(8'h2B, 8'h03);
		wt(2);
		chk(irq_n, 8'h01);
		sig <= 1'h1;
		wt(10);
		chk(irq_n, 8'h00);
		wr(8'h2B, 8'h01);
		wr(8'h2C, 8'h00);
		sig <= 1'h0;
		wt(10);
		chk(irq_n, 8'h01);
		wr(8'h2C, 8'h01);
		wt(2);
		chk(irq_n, 8'h00);
		wr(8'h2B, 8'h03);
		wr(8'h29, 8'h82);
		sig <= 1'h1;
		wt(10);
		chk(irq_n, 8'h01);
		test_done;
	end
endmodule
